// ===== hw/lmsc_strobe_ctrl.sv
// Local-memory strobe and control sequencer
`timescale 1ns/1ps
module lmsc_strobe_ctrl (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic i_refresh,
	input wire logic [lmsc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [lmsc_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_boot_sel,
	input wire logic i_sw_reset,
	input wire logic i_system_reset,
	output logic o_busy,
	output logic o_done,
	output logic o_row_addr_phase,
	output logic o_row_strobe_n,
	output logic o_column_strobe_n,
	output logic o_dram_output_enable_n,
	output logic o_write_strobe_n,
	output logic o_transceiver_direction,
	output logic o_buffer_enable_n,
	output logic o_refresh_indicator,
	output logic o_rom_select_n,
	output logic o_glue_logic_reset_n,
	output logic o_data_oe,
	output logic [lmsc_pkg::DATA_W-1:0] o_wdata
);
	import lmsc_pkg::*;

	lmsc_state_t state_r, state_nxt;
	logic [PH_W-1:0] phase_r, phase_nxt;
	logic wr_r, ref_r, idrom_r, eprom_r;
	logic [ADDR_W-1:0] addr_r;
	logic sysrst_sync;
	logic idrom_hit, eprom_hit;

	function automatic logic in_win(input logic [PH_W-1:0] ph,
		input logic [PH_W-1:0] lo, input logic [PH_W-1:0] hi);
		in_win = (ph >= lo) && (ph <= hi);
	endfunction

	lmsc_sync2 #(.WIDTH(1)) u_sync (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_ce(i_ce),
		.i_async(i_system_reset),
		.o_sync(sysrst_sync)
	);

	lmsc_region_decode u_dec (
		.i_addr(i_addr),
		.i_boot_sel(i_boot_sel),
		.o_idrom_hit(idrom_hit),
		.o_eprom_hit(eprom_hit)
	);

	// Request taken only when idle
	wire accept = i_req && (state_r == ST_IDLE);
	wire last = (state_r == ST_RUN) && (phase_r == PH_LAST);

	always_comb begin
		case (state_r)
			ST_IDLE: begin
				state_nxt = accept ? ST_RUN : ST_IDLE;
				phase_nxt = '0;
			end
			ST_RUN: begin
				state_nxt = last ? ST_IDLE : ST_RUN;
				phase_nxt = last ? '0 : phase_r + 4'h1;
			end
			default: begin
				state_nxt = ST_IDLE;
				phase_nxt = '0;
			end
		endcase
	end

	// Cycle attributes seen by the next output state
	wire wr_nxt = accept ? (i_write && !i_refresh) : wr_r;
	wire ref_nxt = accept ? i_refresh : ref_r;
	wire idrom_nxt = accept ? idrom_hit : idrom_r;
	wire eprom_nxt = accept ? eprom_hit : eprom_r;
	wire [ADDR_W-1:0] addr_nxt = accept ? i_addr : addr_r;
	wire run_nxt = (state_nxt == ST_RUN);
	wire dram_nxt = !idrom_nxt && !eprom_nxt;

	wire row_addr_nxt = run_nxt && (phase_nxt <= PH_ROW_END);
	wire row_win = run_nxt && (ref_nxt ?
		in_win(phase_nxt, PH_REF_RAS_ON, PH_RAS_OFF) :
		in_win(phase_nxt, PH_RAS_ON, PH_RAS_OFF));
	wire cas_win = run_nxt && (ref_nxt ?
		in_win(phase_nxt, PH_REF_CAS_ON, PH_REF_CAS_OFF) :
		(dram_nxt && in_win(phase_nxt, PH_CAS_ON, PH_CAS_OFF)));
	wire data_win = run_nxt && !ref_nxt &&
		in_win(phase_nxt, PH_DATA_ON, PH_LAST);
	wire oe_win = data_win && !wr_nxt && dram_nxt;
	wire we_win = run_nxt && !ref_nxt && wr_nxt &&
		in_win(phase_nxt, PH_WE_ON, PH_WE_OFF);
	wire rom_rd = eprom_nxt && !wr_nxt && !ref_nxt;
	wire rom_early = phase_nxt < PH_A13_ON;
	wire rom_sel_nxt = !run_nxt ? STROBE_IDLE :
		rom_early ? !rom_rd :
		addr_nxt[ROM_A13_BIT];
	wire dir_nxt = accept ? (i_write && !i_refresh) :
		o_transceiver_direction;
	wire glue_nxt = !(i_sw_reset || sysrst_sync);

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= ST_IDLE;
			phase_r <= '0;
			wr_r <= 1'b0;
			ref_r <= 1'b0;
			idrom_r <= 1'b0;
			eprom_r <= 1'b0;
			addr_r <= '0;
		end else if (i_ce) begin
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			wr_r <= wr_nxt;
			ref_r <= ref_nxt;
			idrom_r <= idrom_nxt;
			eprom_r <= eprom_nxt;
			addr_r <= addr_nxt;
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_row_addr_phase <= 1'b0;
			o_row_strobe_n <= STROBE_IDLE;
			o_column_strobe_n <= STROBE_IDLE;
			o_dram_output_enable_n <= STROBE_IDLE;
			o_write_strobe_n <= STROBE_IDLE;
			o_transceiver_direction <= 1'b0;
			o_buffer_enable_n <= STROBE_IDLE;
			o_refresh_indicator <= 1'b0;
			o_rom_select_n <= STROBE_IDLE;
			o_glue_logic_reset_n <= GLUE_RST_VAL;
			o_data_oe <= 1'b0;
			o_wdata <= '0;
		end else if (i_ce) begin
			o_busy <= run_nxt;
			o_done <= last;
			o_row_addr_phase <= row_addr_nxt;
			o_row_strobe_n <= !row_win;
			o_column_strobe_n <= !cas_win;
			o_dram_output_enable_n <= !oe_win;
			o_write_strobe_n <= !we_win;
			o_transceiver_direction <= dir_nxt;
			o_buffer_enable_n <= !data_win;
			o_refresh_indicator <= run_nxt && ref_nxt;
			o_rom_select_n <= rom_sel_nxt;
			o_glue_logic_reset_n <= glue_nxt;
			o_data_oe <= data_win && wr_nxt;
			if (accept) begin
				o_wdata <= i_wdata;
			end
		end
	end

	// Checks on the driven outputs
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst || !i_ce);

	wire run_r = (state_r == ST_RUN);
	wire dram_r = !idrom_r && !eprom_r;

	property p_cas_column;
		run_r && !ref_r && dram_r &&
		in_win(phase_r, PH_CAS_ON, PH_CAS_OFF) |-> !o_column_strobe_n;
	endproperty
	a_cas_column: assert property (p_cas_column)
		else $error("column strobe missing in column phase");

	property p_cas_rom;
		run_r && !ref_r && (idrom_r || eprom_r) |-> o_column_strobe_n;
	endproperty
	a_cas_rom: assert property (p_cas_rom)
		else $error("column strobe on ROM access");

	property p_cas_eprom;
		accept && eprom_hit && !i_refresh |=>
		o_column_strobe_n [*8] ##1 o_column_strobe_n [*8];
	endproperty
	a_cas_eprom: assert property (p_cas_eprom)
		else $error("column strobe during EPROM cycle");

	property p_ref_cbr;
		$rose(o_refresh_indicator) |->
		!o_column_strobe_n && o_row_strobe_n ##2 !o_row_strobe_n;
	endproperty
	a_ref_cbr: assert property (p_ref_cbr)
		else $error("refresh column strobe not ahead of row strobe");

	property p_dir_before_ben;
		$fell(o_buffer_enable_n) |->
		$stable(o_transceiver_direction) && o_busy;
	endproperty
	a_dir_before_ben: assert property (p_dir_before_ben)
		else $error("direction changed as buffer enabled");

	property p_dir_value;
		!o_buffer_enable_n |-> o_transceiver_direction == wr_r;
	endproperty
	a_dir_value: assert property (p_dir_value)
		else $error("direction does not match cycle type");

	property p_oe_dram;
		!o_dram_output_enable_n |-> run_r && !wr_r && !ref_r && dram_r;
	endproperty
	a_oe_dram: assert property (p_oe_dram)
		else $error("output enable outside DRAM read");

	property p_oe_rom;
		run_r && (idrom_r || eprom_r) |-> o_dram_output_enable_n;
	endproperty
	a_oe_rom: assert property (p_oe_rom)
		else $error("output enable on ROM read");

	property p_row_every;
		accept |-> ##[2:5] !o_row_strobe_n;
	endproperty
	a_row_every: assert property (p_row_every)
		else $error("row strobe not asserted in cycle");

	property p_row_addr;
		o_row_addr_phase |-> run_r && phase_r <= PH_ROW_END;
	endproperty
	a_row_addr: assert property (p_row_addr)
		else $error("row address phase too long");

	property p_ref_ind;
		o_refresh_indicator == (run_r && ref_r);
	endproperty
	a_ref_ind: assert property (p_ref_ind)
		else $error("refresh indicator wrong");

	property p_glue;
		i_sw_reset |=> !o_glue_logic_reset_n;
	endproperty
	a_glue: assert property (p_glue)
		else $error("glue reset not driven low");

	property p_rom_early;
		run_r && phase_r < PH_A13_ON |->
		o_rom_select_n == !(eprom_r && !wr_r && !ref_r);
	endproperty
	a_rom_early: assert property (p_rom_early)
		else $error("ROM select wrong in early phase");

	property p_rom_late;
		run_r && phase_r >= PH_A13_ON |->
		o_rom_select_n == addr_r[ROM_A13_BIT];
	endproperty
	a_rom_late: assert property (p_rom_late)
		else $error("ROM select not carrying address bit");

	property p_we_data;
		!o_write_strobe_n |-> wr_r && o_data_oe && $stable(o_wdata);
	endproperty
	a_we_data: assert property (p_we_data)
		else $error("write strobe without held data");

	property p_ref_row;
		$rose(o_refresh_indicator) |-> ##2 (!o_row_strobe_n) [*8] ##1
		(!o_row_strobe_n) [*5] ##1 o_row_strobe_n;
	endproperty
	a_ref_row: assert property (p_ref_row)
		else $error("row strobe wrong in refresh cycle");

	property p_rom_write;
		accept && (i_write || i_boot_sel) |=> o_rom_select_n [*4];
	endproperty
	a_rom_write: assert property (p_rom_write)
		else $error("ROM select low on write or boot one");

	property p_glue_pin;
		sysrst_sync |=> !o_glue_logic_reset_n;
	endproperty
	a_glue_pin: assert property (p_glue_pin)
		else $error("glue reset not driven by system reset");

	property p_glue_rel;
		!i_sw_reset && !sysrst_sync |=> o_glue_logic_reset_n;
	endproperty
	a_glue_rel: assert property (p_glue_rel)
		else $error("glue reset not released");

	property p_ben_data;
		!o_buffer_enable_n |-> run_r && !ref_r && phase_r >= PH_DATA_ON;
	endproperty
	a_ben_data: assert property (p_ben_data)
		else $error("buffer enabled outside data phase");

	c_dram_read: cover property (!o_dram_output_enable_n);
	c_write: cover property ($fell(o_write_strobe_n));
	c_refresh: cover property ($rose(o_refresh_indicator));
	c_rom_read: cover property (!o_rom_select_n && o_busy);
endmodule // lmsc_strobe_ctrl

// ===== hw/lmsc_pkg.sv
// Constants and types for the local-memory strobe and control block
// Behaviour
// - Column strobe low while column address valid
// - No column strobe for identity ROM range
// - No column strobe for EPROM ranges, boot zero
// - Refresh drives column strobe before row strobe
// - Direction valid before buffer enable goes active
// - Output enable low only for DRAM reads
// - Output enable high for ROM reads
// - Row address in first five-sixteenths of cycle
// - Row strobe low every memory cycle
// - Row strobe low during refresh cycles too
// - Refresh indicator high only during refresh
// - Glue reset from software bit or system reset
// - Glue reset active low
// - ROM select low early for EPROM reads
// - ROM select high early for writes, others, boot one
// - ROM select carries address bit 13 late
// - Write strobe low only on write cycles
// - Write data held valid while write strobe low
// - Buffer enable only in data phase
package lmsc_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int PH_W = 4;
	localparam int ROM_A13_BIT = 13;
	localparam logic [4:0] EPROM_CHAP_LO = 5'h00;
	localparam logic [4:0] EPROM_CHAP_HI = 5'h1f;
	localparam logic [15:0] IDROM_LAST_OFS = 16'h000f;
	localparam logic [15:0] EPROM_LO_OFS = 16'h0010;
	localparam logic [PH_W-1:0] PH_LAST = 4'hf;
	localparam logic [PH_W-1:0] PH_ROW_END = 4'h4;
	localparam logic [PH_W-1:0] PH_A13_ON = 4'h4;
	localparam logic [PH_W-1:0] PH_RAS_ON = 4'h1;
	localparam logic [PH_W-1:0] PH_RAS_OFF = 4'he;
	localparam logic [PH_W-1:0] PH_CAS_ON = 4'h6;
	localparam logic [PH_W-1:0] PH_CAS_OFF = 4'he;
	localparam logic [PH_W-1:0] PH_REF_CAS_ON = 4'h0;
	localparam logic [PH_W-1:0] PH_REF_CAS_OFF = 4'hc;
	localparam logic [PH_W-1:0] PH_REF_RAS_ON = 4'h2;
	localparam logic [PH_W-1:0] PH_DATA_ON = 4'h8;
	localparam logic [PH_W-1:0] PH_WE_ON = 4'h9;
	localparam logic [PH_W-1:0] PH_WE_OFF = 4'he;
	localparam logic STROBE_IDLE = 1'b1;
	localparam logic GLUE_RST_VAL = 1'b0;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01
	} lmsc_state_t;
endpackage

// ===== hw/lmsc_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lmsc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_r <= '0;
			o_sync <= '0;
		end else if (i_ce) begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule // lmsc_sync2

// ===== hw/lmsc_region_decode.sv
// Address region decode for identity ROM and EPROM ranges
`timescale 1ns/1ps
module lmsc_region_decode (
	input wire logic [lmsc_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_boot_sel,
	output logic o_idrom_hit,
	output logic o_eprom_hit
);
	import lmsc_pkg::*;

	wire [4:0] chap = i_addr[ADDR_W-1:16];
	wire [15:0] ofs = i_addr[15:0];
	wire chap_lo = (chap == EPROM_CHAP_LO);
	wire chap_hi = (chap == EPROM_CHAP_HI);

	// Identity ROM window
	assign o_idrom_hit = chap_lo && (ofs <= IDROM_LAST_OFS);
	// EPROM windows only when code is in ROM
	assign o_eprom_hit = !i_boot_sel &&
		((chap_lo && (ofs >= EPROM_LO_OFS)) || chap_hi);
endmodule // lmsc_region_decode

// ===== testbench/lmsc_mem_model.sv
// Behavioural memory side: write capture and refresh gating
`timescale 1ns/1ps
module lmsc_mem_model (
	input wire logic i_write_strobe_n,
	input wire logic i_column_strobe_n,
	input wire logic i_refresh_indicator,
	input wire logic [lmsc_pkg::DATA_W-1:0] i_wdata,
	output logic [lmsc_pkg::DATA_W-1:0] o_dram_word,
	output logic [lmsc_pkg::DATA_W-1:0] o_sram_word,
	output logic o_gated_cas_n
);
	import lmsc_pkg::*;
	// Column strobe masked for parts without column-first refresh
	assign o_gated_cas_n = i_column_strobe_n | i_refresh_indicator;
	// Dynamic part latches on the falling write strobe
	always @(negedge i_write_strobe_n) o_dram_word = i_wdata;
	// Static part latches on the rising write strobe
	always @(posedge i_write_strobe_n) o_sram_word = i_wdata;
endmodule // lmsc_mem_model

// ===== testbench/testbench.sv
// Self-checking bench for the local-memory strobe sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
	import lmsc_pkg::*;
	typedef struct {
		logic [4:0] c [10];
		logic wr;
		logic [DATA_W-1:0] wd;
	} lmsc_note_t;
	logic i_mclk, i_nrst, i_ce, i_req, i_write, i_refresh, i_boot_sel;
	logic i_sw_reset, i_system_reset;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_wdata, dram_word, sram_word;
	logic o_busy, o_done, o_rap, o_row_n, o_col_n, o_oe_n, o_we_n, o_dir;
	logic o_buf_n, o_ref, o_rom_n, o_glue_n, o_data_oe;
	logic gcas_n, ce_q;
	logic [9:0] act;
	logic [4:0] cur [10];
	lmsc_note_t q [$];
	lmsc_note_t n;
	int n_fail = 0;
	int checks = 0;
	string nm [10] = '{"row", "col", "buf", "oe", "we", "doe", "rom", "ref",
		"rap", "wdv"};
	localparam logic [20:0] ADRS [9] = '{21'h000000, 21'h00000f, 21'h000010,
		21'h00ffff, 21'h1f0000, 21'h1fffff, 21'h010000, 21'h1e2000, 21'h002000};
	lmsc_strobe_ctrl dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce),
		.i_req(i_req), .i_write(i_write), .i_refresh(i_refresh),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_boot_sel(i_boot_sel),
		.i_sw_reset(i_sw_reset), .i_system_reset(i_system_reset),
		.o_busy(o_busy), .o_done(o_done), .o_row_addr_phase(o_rap),
		.o_row_strobe_n(o_row_n), .o_column_strobe_n(o_col_n),
		.o_dram_output_enable_n(o_oe_n), .o_write_strobe_n(o_we_n),
		.o_transceiver_direction(o_dir), .o_buffer_enable_n(o_buf_n),
		.o_refresh_indicator(o_ref), .o_rom_select_n(o_rom_n),
		.o_glue_logic_reset_n(o_glue_n), .o_data_oe(o_data_oe),
		.o_wdata(o_wdata));
	lmsc_mem_model mem_u (.i_write_strobe_n(o_we_n),
		.i_column_strobe_n(o_col_n), .i_refresh_indicator(o_ref),
		.i_wdata(o_wdata), .o_dram_word(dram_word), .o_sram_word(sram_word),
		.o_gated_cas_n(gcas_n));
	assign act = {~o_we_n & o_data_oe, o_rap, o_ref, ~o_rom_n, o_data_oe,
		~o_we_n, ~o_oe_n, ~o_buf_n, ~o_col_n, ~o_row_n};
	always #2.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) ce_q <= i_ce;
	function automatic lmsc_note_t mk(input logic wr, input logic rf,
		input logic [ADDR_W-1:0] a, input logic bt, input logic [DATA_W-1:0] wd);
		lmsc_note_t e;
		logic idr, ep, w;
		idr = a[20:16] == EPROM_CHAP_LO && a[15:0] <= IDROM_LAST_OFS;
		ep = !bt && ((a[20:16] == EPROM_CHAP_LO && a[15:0] >= EPROM_LO_OFS)
			|| a[20:16] == EPROM_CHAP_HI);
		w = wr && !rf;
		e.wr = w;
		e.wd = wd;
		e.c[0] = rf ? 5'd13 : 5'd14;
		e.c[1] = rf ? 5'd13 : (idr || ep) ? 5'd0 : 5'd9;
		e.c[2] = rf ? 5'd0 : 5'd8;
		e.c[3] = (rf || w || idr || ep) ? 5'd0 : 5'd8;
		e.c[4] = w ? 5'd6 : 5'd0;
		e.c[5] = w ? 5'd8 : 5'd0;
		e.c[6] = ((ep && !w && !rf) ? 5'd4 : 5'd0) + (a[13] ? 5'd0 : 5'd12);
		e.c[7] = rf ? 5'd16 : 5'd0;
		e.c[8] = 5'd5;
		e.c[9] = w ? 5'd6 : 5'd0;
		return e;
	endfunction
	task automatic summarize();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input logic wr, input logic rf,
		input logic [ADDR_W-1:0] a, input logic bt, input logic fz);
		logic [DATA_W-1:0] wd;
		int t;
		wd = DATA_W'($urandom);
		@(negedge i_mclk);
		{i_req, i_write, i_refresh, i_addr, i_boot_sel} = {1'b1, wr, rf, a, bt};
		i_wdata = wd;
		q.push_back(mk(wr, rf, a, bt, wd));
		@(negedge i_mclk);
		i_req = 1'b0;
		repeat (5) @(negedge i_mclk);
		// Request while busy must be ignored
		{i_req, i_write, i_addr} = {1'b1, ~wr, ADDR_W'($urandom)};
		@(negedge i_mclk);
		i_req = 1'b0;
		// Optional freeze in mid-cycle
		if (fz) begin
			i_ce = 1'b0;
			repeat (3) @(negedge i_mclk);
			i_ce = 1'b1;
		end
		t = 0;
		while (o_busy !== 1'b0 && t < 40) begin
			@(negedge i_mclk);
			t++;
		end
		if (t >= 40) begin
			n_fail++;
			$display("[ERR] busy exp 0 got 1");
		end
	endtask
	always @(negedge i_mclk) begin
		if (o_busy === 1'b1 && ce_q === 1'b1)
			for (int k = 0; k < 10; k++) cur[k] += 5'(act[k]);
		if (o_busy === 1'b1 && o_ref === 1'b1)
			`CHK("gcas", 1'b1, gcas_n)
		if (o_done === 1'b1 && ce_q === 1'b1) begin
			if (q.size() == 0) begin
				n_fail++;
				$display("[ERR] done exp none got 1");
			end else begin
				n = q.pop_front();
				for (int k = 0; k < 10; k++) `CHK(nm[k], n.c[k], cur[k])
				`CHK("dir", n.wr, o_dir)
				`CHK("wdata", n.wd, o_wdata)
				if (n.wr) begin
					`CHK("dram", n.wd, dram_word)
					`CHK("sram", n.wd, sram_word)
				end
			end
			for (int k = 0; k < 10; k++) cur[k] = 5'd0;
		end
	end
	initial begin
		i_mclk = 0;
		{i_nrst, i_ce, i_req, i_write, i_refresh, i_boot_sel} = 6'b010000;
		{i_sw_reset, i_system_reset, i_addr, i_wdata} = '0;
		for (int k = 0; k < 10; k++) cur[k] = 5'd0;
		void'($urandom(61369));
		repeat (16) @(posedge i_mclk);
		`CHK("idle", 5'h1f, {o_row_n, o_col_n, o_oe_n, o_we_n, o_rom_n})
		@(negedge i_mclk);
		i_nrst = 1'b1;
		foreach (ADRS[i]) for (int m = 0; m < 4; m++)
			cyc(m[0], 1'b0, ADRS[i], m[1], 1'b0);
		repeat (3) cyc(1'b0, 1'b1, ADDR_W'($urandom), 1'b0, 1'b1);
		repeat (20) cyc(1'($urandom), 1'b0, ADDR_W'($urandom), 1'($urandom),
			1'($urandom));
		@(negedge i_mclk);
		i_sw_reset = 1'b1;
		@(negedge i_mclk);
		`CHK("glue", 1'b0, o_glue_n)
		i_sw_reset = 1'b0;
		repeat (2) @(negedge i_mclk);
		`CHK("glue", 1'b1, o_glue_n)
		i_system_reset = 1'b1;
		repeat (4) @(negedge i_mclk);
		`CHK("glue", 1'b0, o_glue_n)
		i_system_reset = 1'b0;
		repeat (5) @(negedge i_mclk);
		`CHK("glue", 1'b1, o_glue_n)
		summarize();
	end
	initial begin
		repeat (5000) @(posedge i_mclk);
		n_fail++;
		$display("[ERR] watchdog exp done got timeout");
		summarize();
	end
endmodule // testbench
